// ==== verilog/node_ni_defs.vh ====
// constants for the node network interface: register map, fields, timing
//
// Operation
// - combining logic reduces with sum, maximum, OR or XOR; result to one or all
// - broadcast copies one participant's value, control or compute node, to all
// - prefix: participant n receives the combination of inputs one through n
// - segmented prefix restarts the combination at each segment start
// - barrier completes for everyone once all participants have checked in
// - barrier check-in never stalls the processor
// - accepted messages are delivered by the network; receiver must accept them
// - message arrival sets a pollable status flag
// - four-bit tag; supervisor chooses per tag whether arrival interrupts
// - reserved tag used by user code raises an invalid-operation interrupt
// - network refusing an outgoing message sets a pollable failure flag
// - send failure optionally interrupts under an enable
// - network sustains 20, 10, 5 MB/s for group of four, sixteen, anywhere
// - same group of 2^k when addresses differ only in k low bits
// - user registers directly mapped; interrupt control supervisor only
// - both networks apply backpressure without software involvement
`ifndef NODE_NI_DEFS_VH
`define NODE_NI_DEFS_VH

`define ADDR_CN_CTRL 8'h00
`define ADDR_CN_SEND 8'h04
`define ADDR_CN_RESULT 8'h08
`define ADDR_CN_STATUS 8'h0C
`define ADDR_BAR_CHECKIN 8'h10
`define ADDR_DN_DEST 8'h14
`define ADDR_DN_DATA 8'h18
`define ADDR_DN_STATUS 8'h1C
`define ADDR_RX_DATA 8'h20
`define ADDR_RX_INFO 8'h24
`define ADDR_IRQ_STAT 8'h28
`define ADDR_IRQ_MASK 8'h2C
`define ADDR_TAG_IRQ_SEL 8'h30
`define ADDR_TAG_RSVD 8'h34

// combining operation codes, CN_CTRL[2:0]
`define OP_SUM 3'h0
`define OP_MAX 3'h1
`define OP_OR 3'h2
`define OP_XOR 3'h3
`define OP_BCAST 3'h4
// CN_CTRL fields
`define CTL_MODE_BIT 4
`define CTL_SEGSTART_BIT 6
`define CTL_HEAD_BIT 7
`define CTL_BCSRC_BIT 8
`define CTL_WANT_BIT 9
`define CN_CTRL_RESET 10'h200

// interrupt status bits
`define IRQ_RX 0
`define IRQ_SENDFAIL 1
`define IRQ_INVALID 2
`define IRQ_BARRIER 3
`define IRQ_CNDONE 4

`define TAG_RSVD_RESET 16'h0000
`define TAG_IRQ_RESET 16'hFFFF

`define CLK_PERIOD_NS 100
`define SEND_WAIT_NS 1600
`define SEND_WAIT_CYC (`SEND_WAIT_NS / `CLK_PERIOD_NS)

`endif

// ==== verilog/node_network_interface.v ====
// node network interface: combining chain element, barrier, message send and receive
//
// The address map and strobed register access were left to the implementer.
`include "node_ni_defs.vh"
`default_nettype none
module node_network_interface (
  input wire mclk,
  input wire rst_n,
  input wire supervisor,
  input wire [15:0] nodeAddr,
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [31:0] rdData_ff,
  output reg irq_ff,
  input wire cnUpValid,
  input wire [31:0] cnUpData,
  output reg cnUpReady_ff,
  output reg cnDnValid_ff,
  output reg [31:0] cnDnData_ff,
  input wire cnDnReady,
  input wire cnBcValid,
  input wire [31:0] cnBcData,
  output reg barCheckedIn_ff,
  input wire barAllIn,
  output reg dnTxValid_ff,
  output reg [15:0] dnTxDest_ff,
  output reg [3:0] dnTxTag_ff,
  output reg [31:0] dnTxData_ff,
  output reg [1:0] dnTxGroup_ff,
  input wire dnTxReady,
  input wire dnRxValid,
  input wire [15:0] dnRxSrc,
  input wire [3:0] dnRxTag,
  input wire [31:0] dnRxData,
  output reg dnRxReady_ff
);
  localparam [1:0] CN_IDLE = 2'h0;
  localparam [1:0] CN_WAITUP = 2'h1;
  localparam [1:0] CN_SENDDN = 2'h2;
  localparam [1:0] CN_WAITRES = 2'h3;
  // timeout count kept to the counter's width on purpose
  localparam [31:0] SEND_WAIT_W = `SEND_WAIT_CYC;
  localparam [7:0] SEND_WAIT = SEND_WAIT_W[7:0];

  reg [9:0] cnCtrl_ff;
  reg [31:0] cnLocal_ff;
  reg [31:0] cnResult_ff;
  reg cnResValid_ff;
  reg [1:0] cnState_ff;
  reg barDone_ff;
  reg [15:0] dest_ff;
  reg [3:0] tag_ff;
  reg [7:0] waitCnt_ff;
  reg sendFail_ff;
  reg rxFull_ff;
  reg [31:0] rxData_ff;
  reg [15:0] rxSrc_ff;
  reg [3:0] rxTag_ff;
  reg [4:0] irqStat_ff;
  reg [4:0] irqMask_ff;
  reg [15:0] tagIrqSel_ff;
  reg [15:0] tagRsvd_ff;

  reg [1:0] nxt_cnState;
  reg [31:0] combined;
  reg [4:0] evt;
  reg [4:0] clr;
  reg nxt_rxFull;
  reg [31:0] rdVal;
  reg [31:0] headData;
  reg [1:0] grpClass;
  reg [4:0] nxtIrqStat;


  wire [2:0] cnOp = cnCtrl_ff[2:0];
  wire prefixMode = cnCtrl_ff[`CTL_MODE_BIT];
  wire restart = cnCtrl_ff[`CTL_HEAD_BIT] | cnCtrl_ff[`CTL_SEGSTART_BIT];
  wire wrCnSend = regWr && regAddr == `ADDR_CN_SEND;
  wire wrBar = regWr && regAddr == `ADDR_BAR_CHECKIN;
  wire wrData = regWr && regAddr == `ADDR_DN_DATA;
  wire rdPop = regRd && regAddr == `ADDR_RX_DATA;
  wire upTaken = cnUpValid && cnUpReady_ff;
  wire dnTaken = cnDnValid_ff && cnDnReady;
  wire txTaken = dnTxValid_ff && dnTxReady;
  wire txTimeout = dnTxValid_ff && !dnTxReady && waitCnt_ff == SEND_WAIT;
  wire tagIsRsvd = tagRsvd_ff[tag_ff];
  wire badTag = wrData && !supervisor && tagIsRsvd;
  wire sendStart = wrData && !dnTxValid_ff && !badTag;
  wire rxTake = dnRxValid && dnRxReady_ff;

  // combine upstream partial with local value
  always @* begin
    combined = cnLocal_ff;
    if (!restart) begin
      case (cnOp)
        `OP_SUM: combined = cnUpData + cnLocal_ff;
        `OP_MAX: combined = ($signed(cnUpData) > $signed(cnLocal_ff)) ? cnUpData : cnLocal_ff;
        `OP_OR: combined = cnUpData | cnLocal_ff;
        `OP_XOR: combined = cnUpData ^ cnLocal_ff;
        // source injects, everyone else passes the copy along
        `OP_BCAST: combined = cnCtrl_ff[`CTL_BCSRC_BIT] ? cnLocal_ff : cnUpData;
        default: combined = cnLocal_ff;
      endcase
    end else if (cnOp == `OP_BCAST && !cnCtrl_ff[`CTL_BCSRC_BIT]) begin
      combined = 32'h00000000;
    end
  end

  // segment head value; the stale local copy must not be used here
  always @* begin
    headData = regWrData;
    // non-source broadcast head seeds the chain with zero
    if (cnOp == `OP_BCAST && !cnCtrl_ff[`CTL_BCSRC_BIT]) begin
      headData = 32'h00000000;
    end
  end

  // combining chain sequencer
  always @* begin
    nxt_cnState = cnState_ff;
    case (cnState_ff)
      CN_IDLE:
        if (wrCnSend) begin
          // segment start skips the upstream partial
          nxt_cnState = restart ? CN_SENDDN : CN_WAITUP;
        end
      // upstream held off by ready until needed
      CN_WAITUP:
        if (upTaken) begin
          nxt_cnState = CN_SENDDN;
        end
      CN_SENDDN:
        if (dnTaken) begin
          // prefix result is ready once passed on
          nxt_cnState = prefixMode ? CN_IDLE : CN_WAITRES;
        end
      CN_WAITRES:
        if (cnBcValid) begin
          nxt_cnState = CN_IDLE;
        end
      default: nxt_cnState = CN_IDLE;
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnState_ff <= CN_IDLE;
      cnCtrl_ff <= `CN_CTRL_RESET;
      cnLocal_ff <= 32'h00000000;
      cnResult_ff <= 32'h00000000;
      cnResValid_ff <= 1'b0;
      cnUpReady_ff <= 1'b0;
      cnDnValid_ff <= 1'b0;
      cnDnData_ff <= 32'h00000000;
    end else begin
      cnState_ff <= nxt_cnState;
      cnUpReady_ff <= nxt_cnState == CN_WAITUP && !upTaken;
      if (regWr && regAddr == `ADDR_CN_CTRL && cnState_ff == CN_IDLE) begin
        cnCtrl_ff <= regWrData[9:0];
      end
      if (wrCnSend && cnState_ff == CN_IDLE) begin
        cnLocal_ff <= regWrData;
        cnResValid_ff <= 1'b0;
      end
      if ((cnState_ff == CN_WAITUP && upTaken) ||
          (cnState_ff == CN_IDLE && wrCnSend && restart)) begin
        cnDnValid_ff <= 1'b1;
        // segment head must combine the new value, not the stale one
        cnDnData_ff <= (cnState_ff == CN_IDLE) ? headData : combined;
      end else if (dnTaken) begin
        cnDnValid_ff <= 1'b0;
      end
      if (cnState_ff == CN_SENDDN && dnTaken && prefixMode) begin
        cnResult_ff <= cnDnData_ff;
        cnResValid_ff <= 1'b1;
      end
      // reduction result accepted only where wanted
      if (cnState_ff == CN_WAITRES && cnBcValid) begin
        if (cnCtrl_ff[`CTL_WANT_BIT]) begin
          cnResult_ff <= cnBcData;
        end
        cnResValid_ff <= 1'b1;
      end
    end
  end

  // barrier: check-in is only a register write
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      barCheckedIn_ff <= 1'b0;
      barDone_ff <= 1'b0;
    end else begin
      if (wrBar) begin
        barCheckedIn_ff <= 1'b1;
      end else if (barCheckedIn_ff && barAllIn) begin
        barCheckedIn_ff <= 1'b0;
      end
      if (barCheckedIn_ff && barAllIn && !wrBar) begin
        barDone_ff <= 1'b1;
      // done cleared only by the next check-in
      end else if (wrBar) begin
        barDone_ff <= 1'b0;
      end
    end
  end

  // group class from the matching high address bits
  always @* begin
    // class lets the network apply its rate for the distance
    if (dest_ff[15:2] == nodeAddr[15:2]) begin
      grpClass = 2'h0;
    end else if (dest_ff[15:4] == nodeAddr[15:4]) begin
      grpClass = 2'h1;
    end else begin
      grpClass = 2'h2;
    end
  end

  // message send
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dest_ff <= 16'h0000;
      tag_ff <= 4'h0;
      dnTxValid_ff <= 1'b0;
      dnTxDest_ff <= 16'h0000;
      dnTxTag_ff <= 4'h0;
      dnTxData_ff <= 32'h00000000;
      dnTxGroup_ff <= 2'h0;
      waitCnt_ff <= 8'h00;
      sendFail_ff <= 1'b0;
    end else begin
      // destination and tag latched ahead of payload
      if (regWr && regAddr == `ADDR_DN_DEST) begin
        dest_ff <= regWrData[15:0];
        tag_ff <= regWrData[19:16];
      end
      if (sendStart) begin
        dnTxValid_ff <= 1'b1;
        dnTxDest_ff <= dest_ff;
        dnTxTag_ff <= tag_ff;
        dnTxData_ff <= regWrData;
        waitCnt_ff <= 8'h00;
        dnTxGroup_ff <= grpClass;
      // accepted message becomes the network's job
      end else if (txTaken || txTimeout) begin
        dnTxValid_ff <= 1'b0;
      end else if (dnTxValid_ff) begin
        waitCnt_ff <= waitCnt_ff + 8'h01;
      end
      // refused message leaves a poll flag
      if (txTimeout) begin
        sendFail_ff <= 1'b1;
      end else if (sendStart) begin
        sendFail_ff <= 1'b0;
      end
    end
  end

  // message receive: one-deep hold register, backpressure while full
  always @* begin
    nxt_rxFull = rxFull_ff;
    if (rxTake) begin
      nxt_rxFull = 1'b1;
    end else if (rdPop) begin
      nxt_rxFull = 1'b0;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rxFull_ff <= 1'b0;
      rxData_ff <= 32'h00000000;
      rxSrc_ff <= 16'h0000;
      rxTag_ff <= 4'h0;
      dnRxReady_ff <= 1'b0;
    end else begin
      rxFull_ff <= nxt_rxFull;
      // accept from the network when space
      dnRxReady_ff <= !nxt_rxFull;
      if (rxTake) begin
        rxData_ff <= dnRxData;
        rxSrc_ff <= dnRxSrc;
        rxTag_ff <= dnRxTag;
      end
    end
  end

  // interrupt events and supervisor-only control
  always @* begin
    evt = 5'h00;
    evt[`IRQ_RX] = rxTake && tagIrqSel_ff[dnRxTag];
    // failure event, enabled through the mask
    evt[`IRQ_SENDFAIL] = txTimeout;
    evt[`IRQ_INVALID] = badTag;
    evt[`IRQ_BARRIER] = barCheckedIn_ff && barAllIn && !wrBar;
    evt[`IRQ_CNDONE] = (cnState_ff == CN_WAITRES && cnBcValid) ||
                       (cnState_ff == CN_SENDDN && dnTaken && prefixMode);
    clr = 5'h00;
    // user code cannot clear supervisor status
    if (regWr && supervisor && regAddr == `ADDR_IRQ_STAT) begin
      clr = regWrData[4:0];
    end
    // set wins over a simultaneous clear
    nxtIrqStat = (irqStat_ff & ~clr) | evt;
  end


  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_ff <= 5'h00;
      irqMask_ff <= 5'h00;
      tagIrqSel_ff <= `TAG_IRQ_RESET;
      tagRsvd_ff <= `TAG_RSVD_RESET;
      irq_ff <= 1'b0;
    end else begin
      irqStat_ff <= nxtIrqStat;
      // level output registered from the next status, no extra lag
      irq_ff <= |(nxtIrqStat & irqMask_ff);
      if (regWr && supervisor) begin
        case (regAddr)
          `ADDR_IRQ_MASK: irqMask_ff <= regWrData[4:0];
          `ADDR_TAG_IRQ_SEL: tagIrqSel_ff <= regWrData[15:0];
          `ADDR_TAG_RSVD: tagRsvd_ff <= regWrData[15:0];
          default: irqMask_ff <= irqMask_ff;
        endcase
      end
    end
  end


  // read mux; unmapped and unread cycles give zero
  always @* begin
    rdVal = 32'h00000000;
    case (regAddr)
      `ADDR_CN_CTRL: rdVal = {22'h000000, cnCtrl_ff};
      `ADDR_CN_RESULT: rdVal = cnResult_ff;
      `ADDR_CN_STATUS: rdVal = {28'h0000000, barDone_ff, barCheckedIn_ff, cnResValid_ff,
                                cnState_ff != CN_IDLE};
      `ADDR_DN_DEST: rdVal = {12'h000, tag_ff, dest_ff};
      `ADDR_DN_STATUS: rdVal = {29'h00000000, rxFull_ff, sendFail_ff, dnTxValid_ff};
      `ADDR_RX_DATA: rdVal = rxData_ff;
      `ADDR_RX_INFO: rdVal = {12'h000, rxTag_ff, rxSrc_ff};
      `ADDR_IRQ_STAT: rdVal = {27'h0000000, irqStat_ff};
      `ADDR_IRQ_MASK: rdVal = {27'h0000000, irqMask_ff};
      `ADDR_TAG_IRQ_SEL: rdVal = {16'h0000, tagIrqSel_ff};
      `ADDR_TAG_RSVD: rdVal = {16'h0000, tagRsvd_ff};
      default: rdVal = 32'h00000000;
    endcase
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= 32'h00000000;
    end else begin
      rdData_ff <= regRd ? rdVal : 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// ==== bench/node_ni_properties.sv ====
// port checker for the node network interface
`default_nettype none
module node_ni_properties (
  input wire mclk,
  input wire rst_n,
  input wire [15:0] nodeAddr,
  input wire [7:0] regAddr,
  input wire regWr,
  input wire regRd,
  input wire [31:0] rdData_ff,
  input wire cnUpValid,
  input wire cnUpReady_ff,
  input wire cnDnValid_ff,
  input wire [31:0] cnDnData_ff,
  input wire cnDnReady,
  input wire barCheckedIn_ff,
  input wire barAllIn,
  input wire dnTxValid_ff,
  input wire [15:0] dnTxDest_ff,
  input wire [1:0] dnTxGroup_ff,
  input wire dnTxReady,
  input wire dnRxValid,
  input wire dnRxReady_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  AST_RD_ONE: assert property (rdData_ff != 32'h0 |-> $past(regRd))
    else $error("read data without read");
  AST_UP_TAKE: assert property (cnUpValid && cnUpReady_ff |=> cnDnValid_ff && !cnUpReady_ff)
    else $error("no partial after upstream take");
  AST_DN_HOLD: assert property (
    cnDnValid_ff && !cnDnReady |=> cnDnValid_ff && $stable(cnDnData_ff))
    else $error("partial dropped under backpressure");
  AST_BAR_IN: assert property (regWr && regAddr == 8'h10 |=> barCheckedIn_ff)
    else $error("check-in not shown");
  AST_BAR_OUT: assert property (barCheckedIn_ff && barAllIn && !regWr |=> !barCheckedIn_ff)
    else $error("barrier completion not taken");
  AST_TX_START: assert property ($rose(dnTxValid_ff) |-> $past(regWr) && $past(regAddr) == 8'h18)
    else $error("send without payload write");
  AST_TX_DONE: assert property (dnTxValid_ff && dnTxReady |=> !dnTxValid_ff)
    else $error("message kept after acceptance");
  AST_TX_HOLD: assert property (
    dnTxValid_ff && !dnTxReady |=> !dnTxValid_ff || $stable(dnTxDest_ff))
    else $error("destination changed while waiting");
  AST_TX_GROUP: assert property (dnTxValid_ff |-> dnTxGroup_ff ==
    (dnTxDest_ff[15:2] == nodeAddr[15:2] ? 2'h0 : dnTxDest_ff[15:4] == nodeAddr[15:4] ? 2'h1 : 2'h2))
    else $error("wrong group class");
  AST_RX_TAKE: assert property (dnRxValid && dnRxReady_ff |=> !dnRxReady_ff)
    else $error("receive holder not filled");
  cover property (dnTxValid_ff && dnTxReady);
  cover property (barCheckedIn_ff && barAllIn);
  cover property (dnRxValid && dnRxReady_ff);
endmodule
bind node_network_interface node_ni_properties u_node_ni_properties (.mclk, .rst_n, .nodeAddr,
  .regAddr, .regWr, .regRd, .rdData_ff, .cnUpValid, .cnUpReady_ff, .cnDnValid_ff, .cnDnData_ff,
  .cnDnReady, .barCheckedIn_ff, .barAllIn, .dnTxValid_ff, .dnTxDest_ff, .dnTxGroup_ff,
  .dnTxReady, .dnRxValid, .dnRxReady_ff);
`default_nettype wire

// ==== bench/dn_partner.sv ====
// data network model: accepts outgoing messages after a set delay
`default_nettype none
module dn_partner (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic txValid,
  input wire logic [15:0] txDest,
  input wire logic [3:0] txTag,
  input wire logic [31:0] txData,
  input wire logic [7:0] lat,
  output logic txReady,
  output logic [51:0] got,
  output logic [7:0] nAcc
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] waitCnt;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txReady <= 1'b0;
      waitCnt <= 8'h00;
      nAcc <= 8'h00;
      got <= 52'h0;
    end else if (txValid && txReady) begin
      txReady <= 1'b0;
      waitCnt <= 8'h00;
      got <= {txTag, txDest, txData};
      nAcc <= nAcc + 8'h01;
    end else begin
      // a large lat stalls past the sender's patience
      waitCnt <= txValid ? waitCnt + 8'h01 : 8'h00;
      txReady <= txValid && (waitCnt + 8'h01 >= lat);
    end
  end
endmodule
`default_nettype wire

// ==== bench/tb_node_network_interface.sv ====
// self-checking bench for the node network interface
`default_nettype none
module tb_node_network_interface;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_n, supervisor, regWr, regRd, cnUpValid, cnDnReady, cnBcValid, barAllIn;
  logic dnRxValid, supOn;
  logic [7:0] regAddr, lat, nAcc;
  logic [15:0] nodeAddr, dnRxSrc;
  logic [31:0] regWrData, cnUpData, cnBcData, dnRxData, v;
  logic [3:0] dnRxTag;
  logic [51:0] got;
  wire [31:0] rdData_ff, cnDnData_ff, dnTxData_ff;
  wire [15:0] dnTxDest_ff;
  wire [3:0] dnTxTag_ff;
  wire [1:0] dnTxGroup_ff;
  wire irq_ff, cnUpReady_ff, cnDnValid_ff, barCheckedIn_ff, dnTxValid_ff, dnTxReady, dnRxReady_ff;
  int n_mismatch, comparisons, i;
  logic [31:0] ctlT [7] = '{32'h200, 32'h201, 32'h202, 32'h203, 32'h204, 32'h210, 32'h250};
  logic [31:0] expT [7] = '{32'h3, 32'h13, 32'hFFFFFFF3, 32'hFFFFFFE3, 32'hFFFFFFF0, 32'h3, 32'h13};
  logic [15:0] dstT [3] = '{16'h1237, 16'h123C, 16'h9234};
  logic [1:0] grpT [3] = '{2'h0, 2'h1, 2'h2};
  node_network_interface u_node_network_interface (.mclk, .rst_n, .supervisor, .nodeAddr,
    .regAddr, .regWrData, .regWr, .regRd, .rdData_ff, .irq_ff, .cnUpValid, .cnUpData,
    .cnUpReady_ff, .cnDnValid_ff, .cnDnData_ff, .cnDnReady, .cnBcValid, .cnBcData,
    .barCheckedIn_ff, .barAllIn, .dnTxValid_ff, .dnTxDest_ff, .dnTxTag_ff, .dnTxData_ff,
    .dnTxGroup_ff, .dnTxReady, .dnRxValid, .dnRxSrc, .dnRxTag, .dnRxData, .dnRxReady_ff);
  dn_partner u_dn_partner (.mclk, .rst_n, .txValid(dnTxValid_ff), .txDest(dnTxDest_ff),
    .txTag(dnTxTag_ff), .txData(dnTxData_ff), .lat, .txReady(dnTxReady), .got, .nAcc);
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [51:0] e, input logic [51:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    supervisor <= supOn;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    v = rdData_ff;
  endtask
  // upstream partial is -16, local value 0x13
  task automatic cnOp(input logic [31:0] ctl, input logic [31:0] e);
    wr(8'h00, ctl);
    wr(8'h04, 32'h13);
    @(posedge mclk);
    cnUpValid <= !ctl[6];
    cnUpData <= 32'hFFFFFFF0;
    for (i = 0; i < 40 && cnDnValid_ff !== 1'b1; i++) @(negedge mclk);
    chk("cnDnData", e, cnDnData_ff);
    @(posedge mclk);
    cnDnReady <= 1'b1;
    cnUpValid <= 1'b0;
    cnUpData <= 32'h0000000F;
    @(posedge mclk);
    cnDnReady <= 1'b0;
    cnBcValid <= !ctl[4];
    cnBcData <= e;
    @(posedge mclk);
    cnBcValid <= 1'b0;
    rd(8'h08);
    chk("cnResult", e, v);
  endtask
  task automatic rx(input logic [3:0] t, input logic [31:0] d);
    @(posedge mclk);
    dnRxValid <= 1'b1;
    dnRxTag <= t;
    dnRxSrc <= 16'h0042;
    dnRxData <= d;
    for (i = 0; i < 20 && dnRxReady_ff !== 1'b0; i++) @(negedge mclk);
    @(posedge mclk);
    dnRxValid <= 1'b0;
    dnRxData <= ~d;
    rd(8'h1C);
    chk("rxAvail", 1'b1, v[2]);
    rd(8'h24);
    chk("rxInfo", {t, 16'h0042}, v);
    rd(8'h20);
    chk("rxData", d, v);
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    final_report();
  end
  initial begin
    {rst_n, supervisor, regWr, regRd, cnUpValid, cnDnReady, cnBcValid, barAllIn} = 8'h0;
    {dnRxValid, regAddr, regWrData, cnUpData, cnBcData, dnRxData, dnRxSrc, dnRxTag} = 154'h0;
    {supOn, nodeAddr, lat, n_mismatch, comparisons} = {1'b1, 16'h1234, 8'h03, 64'h0};
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h00);
    chk("ctrlReset", 32'h200, v);
    rd(8'h30);
    chk("tagSelReset", 32'hFFFF, v);
    rd(8'h3C);
    chk("unmapped", 32'h0, v);
    wr(8'h2C, 32'h1F);
    supOn = 1'b0;
    wr(8'h2C, 32'h0);
    rd(8'h2C);
    chk("maskUser", 32'h1F, v);
    supOn = 1'b1;
    for (int k = 0; k < 7; k++) cnOp(ctlT[k], expT[k]);
    $display("test combine done");
    wr(8'h28, 32'h1F);
    wr(8'h10, 32'h1);
    @(negedge mclk);
    chk("irqClear", 1'b0, irq_ff);
    chk("barIn", 1'b1, barCheckedIn_ff);
    @(posedge mclk);
    barAllIn <= 1'b1;
    @(posedge mclk);
    barAllIn <= 1'b0;
    rd(8'h0C);
    chk("barDone", 1'b1, v[3]);
    chk("barIrq", 1'b1, irq_ff);
    wr(8'h10, 32'h1);
    rd(8'h0C);
    chk("barDoneNext", 1'b0, v[3]);
    $display("test barrier done");
    for (int k = 0; k < 3; k++) begin
      wr(8'h14, {12'h002, dstT[k]});
      wr(8'h18, 32'hC0DE0000 + k);
      for (i = 0; i < 40 && nAcc !== k + 1; i++) @(negedge mclk);
      chk("sent", {4'h2, dstT[k], 32'hC0DE0000 + k}, got);
      chk("group", grpT[k], dnTxGroup_ff);
    end
    lat = 8'h40;
    wr(8'h18, 32'h5);
    repeat (24) @(posedge mclk);
    rd(8'h1C);
    chk("sendFail", 1'b1, v[1]);
    rd(8'h28);
    chk("sendFailIrq", 1'b1, v[1]);
    lat = 8'h03;
    wr(8'h34, 32'h20);
    supOn = 1'b0;
    wr(8'h14, 32'h51235);
    wr(8'h18, 32'h6);
    repeat (20) @(posedge mclk);
    chk("rsvdNotSent", 8'h03, nAcc);
    rd(8'h28);
    chk("invalidIrq", 1'b1, v[2]);
    supOn = 1'b1;
    $display("test send done");
    wr(8'h28, 32'h1F);
    rx(4'h3, 32'h12345678);
    rd(8'h28);
    chk("rxIrq", 1'b1, v[0]);
    wr(8'h30, 32'h0);
    wr(8'h28, 32'h1F);
    rx(4'h3, 32'h9ABCDEF0);
    rd(8'h28);
    chk("rxIrqOff", 1'b0, v[0]);
    $display("test receive done");
    final_report();
  end
endmodule
`default_nettype wire
